// file: include/arc_pkg.sv
// Package: constants and types for the autorange converter control block
package arc_pkg;
   localparam int CLK_HZ = 25000000;
   // Converter conversion length in converter clock periods
   localparam int CONV_PERIODS = 16400;
   // Converter clock divider: converter clock period in mclk cycles
   localparam int CONV_CLK_DIV = 4;
   localparam int CONV_CYCLES = CONV_PERIODS * CONV_CLK_DIV;
   // Ramp-down phase start, in converter clock periods into the cycle
   localparam int RAMP_DOWN_AT = 8200;
   localparam int DIGIT_SLOT = 64;
   localparam int DIGIT_BLANK = 8;
   localparam int NUM_DIGITS = 4;
   localparam int NUM_RANGES = 4;
   localparam logic [3:0] BCD_BLANK = 4'hF;
   // Top digit code bit positions
   localparam int TD_HALF = 3;
   localparam int TD_SIGN = 2;
   localparam int TD_ONE = 1;
   localparam int TD_FAULT = 0;
   localparam logic [NUM_RANGES-1:0] SHREG_RESET = 4'h0;
   typedef enum logic [1:0] {ARC_VOLT, ARC_CURR, ARC_OHM} arc_func_t;
   typedef struct packed {
      logic [3:0] top;
      logic [3:0] hund;
      logic [3:0] tens;
      logic [3:0] units;
   } arc_result_t;
endpackage

// file: core/arc_range_ctrl.sv
// Module: converter result coder and autorange control for the meter
`timescale 1ns/10ps
module arc_range_ctrl (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic ext_clk_sel,
   input wire logic ext_conv_clk,
   input wire logic display_latch_strobe,
   input wire logic [3:0] result_top,
   input wire logic [3:0] result_hund,
   input wire logic [3:0] result_tens,
   input wire logic [3:0] result_units,
   input wire logic range_hold,
   input wire arc_pkg::arc_func_t func_sel,
   output logic conv_done,
   output logic [3:0] bcd_out,
   output logic [3:0] digit_sel,
   output logic [3:0] top_digit_code,
   output logic range_relay_one,
   output logic range_relay_two,
   output logic range_relay_three,
   output logic range_relay_four,
   output logic [1:0] decimal_point_position,
   output logic ref_2v_sel,
   output logic integ_low_sel,
   output logic [3:0] curr_shunt_sel,
   output logic display_on
);
   import arc_pkg::*;

   // ----------------------------------------
   // Reset and input synchronisers
   // ----------------------------------------
   logic [1:0] rst_sync;
   logic rst_n;
   logic [1:0] strobe_s;
   logic strobe_q;
   logic [1:0] eclk_s;
   logic eclk_q;
   logic [1:0] hold_s;
   logic [1:0] esel_s;

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'h1};
      end
   end
   assign rst_n = rst_sync[1];

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         strobe_s <= 2'h0;
         strobe_q <= 1'h0;
         eclk_s <= 2'h0;
         eclk_q <= 1'h0;
         hold_s <= 2'h0;
         esel_s <= 2'h0;
      end else begin
         strobe_s <= {strobe_s[0], display_latch_strobe};
         strobe_q <= strobe_s[1];
         eclk_s <= {eclk_s[0], ext_conv_clk};
         eclk_q <= eclk_s[1];
         hold_s <= {hold_s[0], range_hold};
         esel_s <= {esel_s[0], ext_clk_sel};
      end
   end

   // ----------------------------------------
   // Converter clock and conversion timing
   // ----------------------------------------
   // External clock edges counted one per period; internal divider otherwise
   logic [$clog2(CONV_CLK_DIV)-1:0] div_cnt;
   logic [$clog2(CONV_PERIODS)-1:0] period_cnt;
   logic tick;
   logic int_tick;
   logic ext_tick;
   logic conv_end;
   logic ramp_down;
   logic latch_armed;
   logic strobe_rise;

   assign int_tick = (int'(div_cnt) == CONV_CLK_DIV - 1);
   assign ext_tick = eclk_s[1] & ~eclk_q;
   assign tick = esel_s[1] ? ext_tick : int_tick;
   assign conv_end = tick && (period_cnt == CONV_PERIODS[$bits(period_cnt)-1:0] - 1'b1);
   assign ramp_down = (period_cnt >= RAMP_DOWN_AT[$bits(period_cnt)-1:0]);
   assign strobe_rise = strobe_s[1] & ~strobe_q;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         div_cnt <= '0;
         period_cnt <= '0;
         conv_done <= 1'h0;
      end else begin
         div_cnt <= int_tick ? '0 : div_cnt + 1'b1;
         if (conv_end) begin
            period_cnt <= '0;
         end else if (tick) begin
            period_cnt <= period_cnt + 1'b1;
         end
         // Internal clock: pulse spans first half of the converter period after the end; one mclk on external clock
         conv_done <= conv_end || (conv_done && !esel_s[1] && (int'(div_cnt) < CONV_CLK_DIV / 2 - 1));
      end
   end

   // ----------------------------------------
   // Result latch and top digit coding
   // ----------------------------------------
   arc_result_t res;
   logic [3:0] next_top;
   logic top_one;
   logic top_zero;
   logic over_r;
   logic under_r;
   logic positive;

   // Sign taken from top digit field value bit 3 (one when negative source)
   assign positive = ~result_top[3];
   assign top_one = (result_top[2:0] == 3'h1) && (result_hund <= 4'h9);
   assign top_zero = (result_top[2:0] == 3'h0);
   assign over_r = (result_top[2:0] > 3'h1);
   assign under_r = top_zero && (result_hund == 4'h0) && (result_tens < 4'h2);
   always_comb begin
      next_top = '0;
      next_top[TD_HALF] = ~(top_one | over_r);
      next_top[TD_SIGN] = positive;
      next_top[TD_ONE] = top_zero | over_r;
      next_top[TD_FAULT] = over_r | under_r;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         latch_armed <= 1'h0;
         res <= '0;
         top_digit_code <= 4'hE;
      end else begin
         if (conv_end) begin
            latch_armed <= 1'h0;
         end else if (strobe_rise && !ramp_down) begin
            latch_armed <= 1'h1;
         end
         // New data only when a strobe edge came before ramp-down
         if (conv_end && (latch_armed || (strobe_rise && !ramp_down))) begin
            res <= '{top: 4'h0, hund: result_hund, tens: result_tens, units: result_units};
            top_digit_code <= next_top;
         end
      end
   end

   // ----------------------------------------
   // Digit multiplexing with inter-digit blanking
   // ----------------------------------------
   logic [$clog2(DIGIT_SLOT)-1:0] slot_cnt;
   logic [1:0] digit_idx;
   logic blank_phase;
   logic [3:0] digit_val;
   logic [3:0] next_digit_sel;

   function automatic logic [3:0] pick_digit(input arc_result_t r, input logic [1:0] idx, input logic [3:0] top);
      case (idx)
         2'h0: pick_digit = top;
         2'h1: pick_digit = r.hund;
         2'h2: pick_digit = r.tens;
         default: pick_digit = r.units;
      endcase
   endfunction

   assign blank_phase = (slot_cnt < DIGIT_BLANK[$bits(slot_cnt)-1:0]);
   assign digit_val = pick_digit(res, digit_idx, top_digit_code);
   assign next_digit_sel = blank_phase ? 4'h0 : (4'h8 >> digit_idx);

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         slot_cnt <= '0;
         digit_idx <= 2'h0;
         digit_sel <= 4'h0;
         bcd_out <= BCD_BLANK;
      end else begin
         slot_cnt <= slot_cnt + 1'b1;
         if (int'(slot_cnt) == DIGIT_SLOT - 1) begin
            digit_idx <= digit_idx + 1'b1;
         end
         digit_sel <= next_digit_sel;
         bcd_out <= blank_phase ? BCD_BLANK : digit_val;
      end
   end

   // ----------------------------------------
   // Range shift register and relay decode
   // ----------------------------------------
   logic [NUM_RANGES-1:0] shreg;
   logic [NUM_RANGES-1:0] next_shreg;
   logic [NUM_RANGES-1:0] relay_dec;
   logic shift_clk;
   logic is_over;
   logic is_under;
   logic full_over;
   logic blink;

   assign is_over = next_top[TD_FAULT] & ~next_top[TD_HALF];
   assign is_under = next_top[TD_FAULT] & next_top[TD_HALF];
   // Hold gates the shift clock, range kept across measurements
   assign shift_clk = conv_end && (is_over || is_under) && !hold_s[1];
   // High level enters at bit 0 moving right, ones leave moving left
   assign next_shreg = is_over ? {shreg[NUM_RANGES-2:0], 1'b1} : {1'b0, shreg[NUM_RANGES-1:1]};

   genvar gi;
   generate
      for (gi = 0; gi < NUM_RANGES; gi++) begin : g_dec
         if (gi == 0) begin : g_first
            assign relay_dec[gi] = ~shreg[0];
         end else if (gi < NUM_RANGES - 1) begin : g_rest
            assign relay_dec[gi] = shreg[gi-1] ^ shreg[gi];
         end else begin : g_top // Saturated all-ones word still picks the top range
            assign relay_dec[gi] = shreg[gi-1];
         end
      end
   endgenerate
   assign full_over = is_over && (shreg == {NUM_RANGES{1'b1}});

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         shreg <= SHREG_RESET;
         blink <= 1'h0;
         display_on <= 1'h1;
         {range_relay_four, range_relay_three, range_relay_two, range_relay_one} <= 4'h1;
         decimal_point_position <= 2'h0;
         ref_2v_sel <= 1'h0;
         integ_low_sel <= 1'h0;
         curr_shunt_sel <= 4'h0;
      end else begin
         if (shift_clk) begin
            shreg <= next_shreg;
         end
         if (conv_end) begin
            blink <= full_over ? ~blink : 1'h0;
         end
         display_on <= ~blink;
         {range_relay_four, range_relay_three, range_relay_two, range_relay_one} <= relay_dec;
         decimal_point_position <= func_sel == ARC_VOLT && relay_dec[0] ? 2'h1 :
                                   relay_dec[0] ? 2'h3 : relay_dec[1] ? 2'h2 : 2'h1;
         ref_2v_sel <= (func_sel == ARC_OHM) || (func_sel == ARC_VOLT && !relay_dec[0]);
         integ_low_sel <= (func_sel == ARC_VOLT) && relay_dec[0];
         curr_shunt_sel <= (func_sel == ARC_CURR) ? relay_dec : 4'h0;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_relay_one_hot: assert property (@(posedge mclk) disable iff (!rst_n)
      $onehot({range_relay_four, range_relay_three, range_relay_two, range_relay_one}))
      else $error("relay lines not one-hot");
   a_shift_in_range: assert property (@(posedge mclk) disable iff (!rst_n)
      (conv_end && !next_top[TD_FAULT]) |=> $stable(shreg))
      else $error("shift on in-range result");
   a_hold_blocks: assert property (@(posedge mclk) disable iff (!rst_n)
      hold_s[1] |=> $stable(shreg))
      else $error("shift while range held");
   a_over_right: assert property (@(posedge mclk) disable iff (!rst_n)
      shift_clk && is_over |=> shreg == {$past(shreg[NUM_RANGES-2:0]), 1'b1})
      else $error("over-range shift wrong");
   a_sel_blank: assert property (@(posedge mclk) disable iff (!rst_n)
      digit_sel == 4'h0 |-> bcd_out == BCD_BLANK)
      else $error("bcd not blank between selects");
   a_ref_ohm: assert property (@(posedge mclk) disable iff (!rst_n)
      func_sel == ARC_OHM |=> ref_2v_sel)
      else $error("ohms not on 2 V reference");
   a_integ_sel: assert property (@(posedge mclk) disable iff (!rst_n)
      integ_low_sel |-> $past(func_sel) == ARC_VOLT && range_relay_one)
      else $error("integrator switch outside low volt range");
   a_done_short: assert property (@(posedge mclk) disable iff (!rst_n)
      conv_done [*2] |=> !conv_done)
      else $error("conversion done pulse too long");
endmodule // arc_range_ctrl

// file: verification/arc_conv_model.sv
// Partner model: external converter clock and display strobe wiring
`timescale 1ns/10ps
module arc_conv_model (
   input wire logic mclk,
   input wire logic conv_done,
   input wire logic kick,
   output logic ext_conv_clk,
   output logic display_latch_strobe
);
   // ------------------------------------------------------------
   // Clock and strobe
   // ------------------------------------------------------------
   // Edges fall between mclk samples, so each level is seen exactly once
   always @(negedge mclk) begin
      ext_conv_clk <= !(ext_conv_clk === 1'b1);
   end
   // Kick covers the first conversion, which has no earlier done pulse
   assign display_latch_strobe = conv_done | kick;
endmodule // arc_conv_model

// file: verification/test_arc_range_ctrl.sv
// Testbench for the autorange converter control block
`timescale 1ns/10ps
module test_arc_range_ctrl;
   import arc_pkg::*;
   logic mclk = 1'b0;
   logic arst_n = 1'b0;
   logic range_hold = 1'b0;
   logic kick = 1'b0;
   arc_func_t func_sel = ARC_VOLT;
   logic [3:0] result_top = 4'h0;
   logic [3:0] result_hund = 4'h0;
   logic [3:0] result_tens = 4'h0;
   logic [3:0] result_units = 4'h0;
   wire ext_conv_clk;
   wire display_latch_strobe;
   logic conv_done, ref_2v_sel, integ_low_sel, display_on;
   logic range_relay_one, range_relay_two, range_relay_three, range_relay_four;
   logic [3:0] bcd_out, digit_sel, top_digit_code, curr_shunt_sel;
   logic [1:0] decimal_point_position;
   wire [3:0] relays = {range_relay_four, range_relay_three, range_relay_two, range_relay_one};
   wire [3:0] refs = {2'b00, ref_2v_sel, integ_low_sel};
   int mismatches = 0;
   int tests_run = 0;
   always #20 mclk = ~mclk;
   arc_conv_model arc_conv_model_i (.mclk(mclk), .conv_done(conv_done), .kick(kick),
      .ext_conv_clk(ext_conv_clk), .display_latch_strobe(display_latch_strobe));
   arc_range_ctrl arc_range_ctrl_i (.mclk(mclk), .arst_n(arst_n), .ext_clk_sel(1'b1),
      .ext_conv_clk(ext_conv_clk), .display_latch_strobe(display_latch_strobe),
      .result_top(result_top), .result_hund(result_hund), .result_tens(result_tens),
      .result_units(result_units), .range_hold(range_hold), .func_sel(func_sel),
      .conv_done(conv_done), .bcd_out(bcd_out), .digit_sel(digit_sel),
      .top_digit_code(top_digit_code), .range_relay_one(range_relay_one),
      .range_relay_two(range_relay_two), .range_relay_three(range_relay_three),
      .range_relay_four(range_relay_four), .decimal_point_position(decimal_point_position),
      .ref_2v_sel(ref_2v_sel), .integ_low_sel(integ_low_sel), .curr_shunt_sel(curr_shunt_sel),
      .display_on(display_on));
   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic step(input int n);
      repeat (n) @(posedge mclk);
      #5;
   endtask
   task automatic chk(input logic [3:0] got, input logic [3:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic load(input logic [3:0] t, input logic [3:0] h, input logic [3:0] d, input logic [3:0] u);
      result_top = t;
      result_hund = h;
      result_tens = d;
      result_units = u;
   endtask
   // Bounded wait for the done pulse; conversions run about 32800 mclk here
   task automatic wait_conv();
      int n;
      n = 0;
      while (conv_done !== 1'b1 && n < 40000) begin
         step(1);
         n++;
      end
      chk({3'b000, conv_done}, 4'h1);
      step(1);
      chk({3'b000, conv_done}, 4'h0);
      step(3);
   endtask
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      step(1);
      chk(relays, 4'h1);
      chk(digit_sel, 4'h0);
      step(11);
      arst_n = 1'b1;
      step(6);
      chk(refs, 4'h1);
      kick = 1'b1;
      step(4);
      kick = 1'b0;
   endtask
   task automatic t_over();
      load(4'h2, 4'h5, 4'h3, 4'h7);
      wait_conv();
      chk(top_digit_code, 4'h7);
      chk(relays, 4'h2);
      chk(refs, 4'h2);
      func_sel = ARC_CURR;
      step(4);
      chk(refs, 4'h0);
      chk(curr_shunt_sel, 4'h2);
      func_sel = ARC_OHM;
      step(4);
      chk(refs, 4'h2);
      func_sel = ARC_VOLT;
      // Every select must carry its own digit, blanking shows F
      for (int i = 0; i < 300; i++) begin
         step(1);
         if (digit_sel === 4'h8) chk(bcd_out, 4'h7);
         else if (digit_sel === 4'h4) chk(bcd_out, 4'h5);
         else if (digit_sel === 4'h2) chk(bcd_out, 4'h3);
         else if (digit_sel === 4'h1) chk(bcd_out, 4'h7);
         else if (digit_sel === 4'h0) chk(bcd_out, BCD_BLANK);
      end
   endtask
   task automatic t_hold();
      range_hold = 1'b1;
      load(4'hA, 4'h0, 4'h0, 4'h0);
      wait_conv();
      chk(top_digit_code, 4'h3);
      chk(relays, 4'h2);
      range_hold = 1'b0;
   endtask
   task automatic t_under();
      load(4'h0, 4'h0, 4'h0, 4'h0);
      wait_conv();
      chk(top_digit_code, 4'hF);
      chk(relays, 4'h1);
      chk({3'b000, display_on}, 4'h1);
   endtask
   initial begin
      t_reset();
      t_over();
      t_hold();
      t_under();
      wrap_up();
   end
   // Three conversions of about 32800 cycles each, with margin
   initial begin
      repeat (100000) @(posedge mclk);
      mismatches++;
      wrap_up();
   end
endmodule // test_arc_range_ctrl
